// *** serial_port_pkg.sv ***
// shared constants and types for the slave serial read and configuration port
package serial_port_pkg;

  // result word and queue sizing
  localparam int RESULT_WIDTH = 16;
  localparam int FIFO_DEPTH = 32;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;

  // configuration register layout
  localparam int CFG_WIDTH = 9;
  localparam logic [8:0] CFG_RESET = 9'h000;
  localparam logic [8:0] CFG_WRITE_MASK = 9'h1fc;
  localparam logic [3:0] CFG_LAST_EDGE = 4'h8;
  localparam int CFG_START = 8;
  localparam int CFG_BIPOLAR = 7;
  localparam int CFG_WIDE_SPAN = 6;
  localparam int CFG_POWER_DOWN = 5;
  localparam int CFG_LOW_POWER = 4;
  localparam int CFG_FAST = 3;
  localparam int CFG_CODING = 2;

  // positions of the pins inside the synchroniser vector
  localparam int SYNC_WIDTH = 17;
  localparam int SY_SERIAL_DATA_CLOCK = 0;
  localparam int SY_CCLK = 1;
  localparam int SY_CHAIN = 2;
  localparam int SY_CS = 3;
  localparam int SY_RD = 4;
  localparam int SY_SER = 5;
  localparam int SY_EXT = 6;
  localparam int SY_INV = 7;
  localparam int SY_HWSW = 8;
  localparam int SY_CSEL = 9;
  localparam int SY_CDIN = 10;
  localparam int SY_HW_LSB = 11;
  localparam int SY_HW_MSB = 16;

  // readout frame states
  typedef enum logic [1:0] {
    FR_IDLE = 2'b01,
    FR_OPEN = 2'b10
  } frame_state_t;

  // decoded speed modes
  typedef enum logic [2:0] {
    SPEED_NORMAL = 3'b001,
    SPEED_LOW_POWER = 3'b010,
    SPEED_FAST = 3'b100
  } speed_mode_t;

endpackage

// *** word_stream_if.sv ***
// valid/ready word stream between the port logic and its result queue
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int WIDTH = 16) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface // word_stream_if
`default_nettype wire

// *** pin_sync.sv ***
// two-stage synchroniser with edge detection for a vector of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // raw pins and their sampled forms
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] last_q;

  // meta_q feeds only stable_q; edges compare later stages
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      stable_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pin_i;
      stable_q <= meta_q;
      last_q <= stable_q;
    end
  end

  // edge pulses last one mclk cycle
  assign level_o = stable_q;
  assign rise_o = stable_q & ~last_q;
  assign fall_o = ~stable_q & last_q;
endmodule // pin_sync
`default_nettype wire

// *** result_fifo.sv ***
// result queue with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // fill and drain sides
  word_stream_if.sink push,
  word_stream_if.source pop
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [CW-1:0] count_q, count_d;
  logic ready_q;
  wire do_push = push.valid & ready_q;
  wire do_pop = pop.ready & (count_q != '0);

  // count moves by at most one per cycle
  assign count_d = count_q + CW'(do_push) - CW'(do_pop);
  assign push.ready = ready_q;
  assign pop.valid = (count_q != '0);
  assign pop.data = mem_q[rd_ptr_q];

  // pointers and registered ready, so a full queue stalls the source
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (do_push) wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (do_pop) rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_d;
      ready_q <= (count_d != FULL_COUNT);
    end
  end

  // storage has no reset
  always_ff @(posedge mclk_i) begin
    if (do_push) mem_q[wr_ptr_q] <= push.data;
  end
endmodule // result_fifo
`default_nettype wire

// *** slave_serial_read_and_config_port.sv ***
// slave serial result readout with daisy chain and serial configuration port
// What this block does
// - serial and external clock selects high: results shift on the external data clock
// - data clock gated by chip select; shifting only with select and read enable low
// - data clock may idle high or low; no setting needed for idle level
// - after busy falls, new result goes out MSB first over 16 clocks
// - chain input sampled on edge opposite the shift edge, feeding after local LSB
// - read during conversion gives previous result; unfinished read pulses read error
// - read may start after conversion and finish after next one begins
// - hardware modes take range, speed, coding, power down from dedicated pins
// - software configuration mode ignores the dedicated configuration pins
// - configuration port works only with serial selected and software config chosen
// - host selects config port, then clocks data on the clock-inversion-chosen edge
// - config bits enter MSB first from start bit; ninth edge commits settings
// - the two lowest configuration bits are reserved and never written
// - reset clears the configuration register to all zeros
// - bit 7 bipolar, bit 6 ten-volt span select the input range
// - bits 4 and 3 select low power, fast or normal speed
// - bit 5 powers down; port stays usable; writing it low restores operation
// - bit 2 selects twos complement when low, straight binary when high
`timescale 1ns/1ps
`default_nettype none
module slave_serial_read_and_config_port import serial_port_pkg::*; #(
  parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // converter core side, same clock
  input wire logic busy_i,
  input wire logic [RESULT_WIDTH-1:0] result_i,
  input wire logic result_valid_i,
  output logic result_ready_o,
  // interface mode straps
  input wire logic serial_not_parallel_select_i,
  input wire logic external_clock_select_i,
  input wire logic clock_invert_i,
  input wire logic hardware_not_software_config_i,
  // serial readout pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic serial_data_clock_i,
  input wire logic chain_input_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  output logic read_error_o,
  // serial configuration port pins
  input wire logic config_select_n_i,
  input wire logic config_clock_i,
  input wire logic config_data_in_i,
  // dedicated hardware configuration pins
  input wire logic hw_bipolar_i,
  input wire logic hw_wide_span_i,
  input wire logic hw_power_down_i,
  input wire logic hw_low_power_i,
  input wire logic hw_fast_i,
  input wire logic hw_output_coding_i,
  // settings in force
  output logic range_bipolar_o,
  output logic range_wide_span_o,
  output logic power_down_o,
  output logic [2:0] speed_mode_o,
  output logic output_coding_o
);
  localparam int MSB = RESULT_WIDTH - 1;

  logic [SYNC_WIDTH-1:0] pins_w, lvl_w, rise_w, fall_w;
  frame_state_t state_q, state_d;
  logic [RESULT_WIDTH-1:0] shreg_q, shreg_d, hold_q, hold_d;
  logic [4:0] cnt_q, cnt_d;
  logic loaded_q, loaded_d, during_q, during_d;
  logic chain_q, oe_q, err_q, busy_prev_q;
  logic [CFG_WIDTH-1:0] cfg_q, cfg_shift_q;
  logic [3:0] cfg_cnt_q;
  logic bipolar_q, wide_q, pd_q, coding_q;
  speed_mode_t speed_q;

  word_stream_if #(.WIDTH(RESULT_WIDTH)) push_if ();
  word_stream_if #(.WIDTH(RESULT_WIDTH)) pop_if ();

  // every pin crosses two flops; hardware pins land in config bit order
  assign pins_w = {hw_bipolar_i, hw_wide_span_i, hw_power_down_i, hw_low_power_i, hw_fast_i,
                   hw_output_coding_i, config_data_in_i, config_select_n_i,
                   hardware_not_software_config_i, clock_invert_i, external_clock_select_i,
                   serial_not_parallel_select_i, rd_n_i, cs_n_i, chain_input_i,
                   config_clock_i, serial_data_clock_i};

  pin_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(pins_w),
    .level_o(lvl_w),
    .rise_o(rise_w),
    .fall_o(fall_w)
  );

  // results queue up so a slow reader can span the next conversion
  assign push_if.valid = result_valid_i;
  assign push_if.data = result_i;
  assign result_ready_o = push_if.ready;

  result_fifo #(.WIDTH(RESULT_WIDTH), .DEPTH(QUEUE_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .push(push_if.sink),
    .pop(pop_if.source)
  );

  // readout enables and data clock edges
  wire serial_w = lvl_w[SY_SER];
  wire ext_mode_w = serial_w & lvl_w[SY_EXT];
  wire frame_en_w = ext_mode_w & ~lvl_w[SY_CS] & ~lvl_w[SY_RD];
  // edges only, never levels, so either idle level works
  wire shift_edge_w = lvl_w[SY_INV] ? fall_w[SY_SERIAL_DATA_CLOCK] : rise_w[SY_SERIAL_DATA_CLOCK];
  wire sample_edge_w = lvl_w[SY_INV] ? rise_w[SY_SERIAL_DATA_CLOCK] : fall_w[SY_SERIAL_DATA_CLOCK];
  wire busy_fall_w = busy_prev_q & ~busy_i;

  // configuration port enables and source selection
  wire sw_mode_w = serial_w & ~lvl_w[SY_HWSW];
  wire cfg_edge_w = lvl_w[SY_INV] ? fall_w[SY_CCLK] : rise_w[SY_CCLK];
  wire cfg_clk_w = sw_mode_w & ~lvl_w[SY_CSEL] & cfg_edge_w;
  wire [CFG_WIDTH-1:0] hw_cfg_w = {1'b0, lvl_w[SY_HW_MSB:SY_HW_LSB], 2'b00};
  wire [CFG_WIDTH-1:0] eff_cfg_w = sw_mode_w ? cfg_q : hw_cfg_w;
  wire [CFG_WIDTH-1:0] commit_w = {cfg_shift_q[CFG_WIDTH-2:0], lvl_w[SY_CDIN]} & CFG_WRITE_MASK;

  // straight binary is twos complement with the sign bit flipped
  wire [RESULT_WIDTH-1:0] coded_w = {pop_if.data[MSB] ^ eff_cfg_w[CFG_CODING],
                                     pop_if.data[MSB-1:0]};
  wire load_w = (state_q == FR_IDLE) & ~loaded_q & pop_if.valid;
  assign pop_if.ready = load_w;

  // speed decode: unequal bits pick a mode, equal bits mean normal
  wire low_sel_w = eff_cfg_w[CFG_LOW_POWER] & ~eff_cfg_w[CFG_FAST];
  wire fast_sel_w = ~eff_cfg_w[CFG_LOW_POWER] & eff_cfg_w[CFG_FAST];
  wire [2:0] speed_w = low_sel_w ? SPEED_LOW_POWER : (fast_sel_w ? SPEED_FAST : SPEED_NORMAL);

  // frame sequencing and output shifter
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    hold_d = hold_q;
    cnt_d = cnt_q;
    loaded_d = loaded_q;
    during_d = during_q;
    unique case (state_q)
      FR_IDLE: begin
        if (load_w) begin
          shreg_d = coded_w;
          hold_d = coded_w;
          loaded_d = 1'b1;
        end
        if (frame_en_w) begin
          state_d = FR_OPEN;
          cnt_d = 5'h00;
          during_d = busy_i;
        end
      end
      FR_OPEN: begin
        if (!frame_en_w) begin
          state_d = FR_IDLE;
          // a partial read keeps the word for the next frame
          if (cnt_q >= BITS_PER_WORD) begin
            loaded_d = 1'b0;
          end else begin
            shreg_d = hold_q;
          end
        end else if (shift_edge_w) begin
          // past 16 bits the upstream chain data follows
          shreg_d = {shreg_q[MSB-1:0], chain_q};
          if (cnt_q < BITS_PER_WORD) cnt_d = cnt_q + 5'h01;
        end
      end
      default: state_d = FR_IDLE;
    endcase
    if (busy_fall_w) during_d = 1'b0;
  end

  // frame registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= FR_IDLE;
      shreg_q <= '0;
      hold_q <= '0;
      cnt_q <= 5'h00;
      loaded_q <= 1'b0;
      during_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      hold_q <= hold_d;
      cnt_q <= cnt_d;
      loaded_q <= loaded_d;
      during_q <= during_d;
    end
  end

  // chain input caught on the edge opposite the shift edge; while idle it follows the pin,
  // since the upstream MSB already stands there before the first shift edge of a frame
  wire chain_take_w = (state_q == FR_IDLE) | (frame_en_w & sample_edge_w);
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chain_q <= 1'b0;
    end else if (chain_take_w) begin
      chain_q <= lvl_w[SY_CHAIN];
    end
  end

  // output enable, busy edge and read error pulse
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oe_q <= 1'b0;
      err_q <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      oe_q <= (state_d == FR_OPEN);
      err_q <= busy_fall_w & during_q & (cnt_q < BITS_PER_WORD);
      busy_prev_q <= busy_i;
    end
  end

  // configuration shift register; power down never blocks it
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= CFG_RESET;
      cfg_shift_q <= CFG_RESET;
      cfg_cnt_q <= 4'h0;
    end else if (!sw_mode_w || lvl_w[SY_CSEL]) begin
      cfg_cnt_q <= 4'h0;
    end else if (cfg_clk_w) begin
      cfg_shift_q <= {cfg_shift_q[CFG_WIDTH-2:0], lvl_w[SY_CDIN]};
      if (cfg_cnt_q == CFG_LAST_EDGE) begin
        cfg_q <= commit_w;
        cfg_cnt_q <= 4'h0;
      end else begin
        cfg_cnt_q <= cfg_cnt_q + 4'h1;
      end
    end
  end

  // settings in force, registered for the analog side
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bipolar_q <= 1'b0;
      wide_q <= 1'b0;
      pd_q <= 1'b0;
      coding_q <= 1'b0;
      speed_q <= SPEED_NORMAL;
    end else begin
      bipolar_q <= eff_cfg_w[CFG_BIPOLAR];
      wide_q <= eff_cfg_w[CFG_WIDE_SPAN];
      pd_q <= eff_cfg_w[CFG_POWER_DOWN];
      coding_q <= eff_cfg_w[CFG_CODING];
      speed_q <= speed_mode_t'(speed_w);
    end
  end

  assign serial_result_out_o = shreg_q[MSB];
  assign serial_result_oe_o = oe_q;
  assign read_error_o = err_q;
  assign range_bipolar_o = bipolar_q;
  assign range_wide_span_o = wide_q;
  assign power_down_o = pd_q;
  assign output_coding_o = coding_q;
  assign speed_mode_o = speed_q;

  // checks
  closed_quiet_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !frame_en_w |=> !serial_result_oe_o)
    else $error("output driven while select or read enable high");
  shift_cause_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ($changed(cnt_q) && cnt_q != 5'h00) |-> $past(frame_en_w) && $past(shift_edge_w))
    else $error("bit count moved without a gated clock edge");
  msb_first_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ($rose(serial_result_oe_o) && loaded_q) |-> serial_result_out_o == hold_q[MSB])
    else $error("frame did not open on the result MSB");
  chain_follow_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FR_OPEN && frame_en_w && shift_edge_w) |=> shreg_q[0] == $past(chain_q))
    else $error("chain bit not shifted in behind local data");
  error_pulse_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    read_error_o |=> !read_error_o)
    else $error("read error longer than one cycle");
  error_cause_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    read_error_o |-> $past(busy_i, 2) && !$past(busy_i))
    else $error("read error without end of conversion");
  cfg_commit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (cfg_clk_w && cfg_cnt_q == CFG_LAST_EDGE) |=> cfg_q == $past(commit_w))
    else $error("ninth config edge did not commit");
  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cfg_q[1:0] == 2'b00)
    else $error("reserved config bits written");
  sw_power_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sw_mode_w |=> power_down_o == $past(cfg_q[CFG_POWER_DOWN]))
    else $error("power down not taken from config register");
  speed_map_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    low_sel_w |=> speed_mode_o == SPEED_LOW_POWER)
    else $error("low power speed not decoded");
endmodule // slave_serial_read_and_config_port
`default_nettype wire

// *** host_serial_model.sv ***
// host serial controller model: data clock, read selects and configuration stream
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  // clock and clock inversion level
  input wire logic mclk_i,
  input wire logic clock_invert_i,
  // readout pins
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic sclk_o,
  // configuration port pins
  output logic csel_n_o,
  output logic cclk_o,
  output logic cdin_o
);
  logic sact_q = 1'b0;
  logic cact_q = 1'b0;

  // clocks rest at the inversion level, so the first move is the active edge
  assign sclk_o = sact_q ^ clock_invert_i;
  assign cclk_o = cact_q ^ clock_invert_i;

  // idle pins at time zero
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    csel_n_o = 1'b1;
    cdin_o = 1'b0;
  end

  // lower both selects, then give the device time to open the frame
  task automatic open_frame();
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask

  task automatic close_frame();
    @(posedge mclk_i);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (5) @(posedge mclk_i);
  endtask

  // 100 ns halves: slow enough for mclk sampling and for a chained device
  task automatic shift_bits(input int n, output logic [31:0] bits);
    bits = '0;
    for (int i = 0; i < n; i++) begin
      bits = {bits[30:0], sdo_i};
      sact_q <= 1'b1;
      repeat (4) @(posedge mclk_i);
      sact_q <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask

  // select first, then nine bits msb first, data set a third of a period ahead
  task automatic cfg_write(input logic [8:0] v);
    @(posedge mclk_i);
    csel_n_o <= 1'b0;
    for (int i = 8; i >= 0; i--) begin
      repeat (4) @(posedge mclk_i);
      cdin_o <= v[i];
      repeat (4) @(posedge mclk_i);
      cact_q <= 1'b1;
      repeat (4) @(posedge mclk_i);
      cact_q <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    csel_n_o <= 1'b1;
    cdin_o <= ~cdin_o; // released data line shows no stale value
    repeat (8) @(posedge mclk_i);
  endtask
endmodule // host_serial_model
`default_nettype wire

// *** slave_serial_read_and_config_port_bench.sv ***
// self-checking bench for the slave serial read and configuration port
`timescale 1ns/1ps
`default_nettype none
module slave_serial_read_and_config_port_bench;
  typedef struct packed {logic inv; logic [8:0] cfg; logic [15:0] word; logic [6:0] exp;} row_t;
  logic mclk = 1'b0, rst = 1'b1, busy = 1'b0, valid = 1'b0, ser = 1'b1, ext = 1'b1;
  logic inv = 1'b0, hwsw = 1'b0, chain = 1'b0;
  logic [5:0] hwp = 6'h3f;
  logic [15:0] result = 16'h0000;
  logic [31:0] bits, b2;
  wire logic ready, sdo, oe, rderr, bip, wide, pd, coding, cs_n, rd_n, sclk, csel_n, cclk, cdin;
  wire logic [2:0] speed;
  wire logic [6:0] setting = {bip, wide, pd, speed, coding};
  int num_errors = 0, total_checks = 0, n_err_pulses = 0, n = 0;
  // settings as {bipolar, wide span, power down, speed one-hot, coding}
  row_t rows [9] = '{'{1'h0, 9'h100, 16'h1234, 7'h02}, '{1'h1, 9'h140, 16'hbeef, 7'h22},
    '{1'h0, 9'h180, 16'h8001, 7'h42}, '{1'h1, 9'h110, 16'h0000, 7'h04},
    '{1'h0, 9'h108, 16'hffff, 7'h08}, '{1'h1, 9'h118, 16'h5a5a, 7'h02},
    '{1'h0, 9'h104, 16'h7fff, 7'h03}, '{1'h1, 9'h123, 16'h0f0f, 7'h12},
    '{1'h0, 9'h100, 16'hc3c3, 7'h02}};

  slave_serial_read_and_config_port i_dut (
    .mclk_i(mclk), .sys_rst_i(rst), .busy_i(busy), .result_i(result),
    .result_valid_i(valid), .result_ready_o(ready),
    .serial_not_parallel_select_i(ser), .external_clock_select_i(ext),
    .clock_invert_i(inv), .hardware_not_software_config_i(hwsw),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .serial_data_clock_i(sclk), .chain_input_i(chain),
    .serial_result_out_o(sdo), .serial_result_oe_o(oe), .read_error_o(rderr),
    .config_select_n_i(csel_n), .config_clock_i(cclk), .config_data_in_i(cdin),
    .hw_bipolar_i(hwp[5]), .hw_wide_span_i(hwp[4]), .hw_power_down_i(hwp[3]),
    .hw_low_power_i(hwp[2]), .hw_fast_i(hwp[1]), .hw_output_coding_i(hwp[0]),
    .range_bipolar_o(bip), .range_wide_span_o(wide), .power_down_o(pd),
    .speed_mode_o(speed), .output_coding_o(coding));

  host_serial_model i_host (
    .mclk_i(mclk), .clock_invert_i(inv), .sdo_i(sdo), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .sclk_o(sclk), .csel_n_o(csel_n), .cclk_o(cclk), .cdin_o(cdin));

  // 40 MHz system clock
  always #12.5 mclk = ~mclk;

  // count read error pulses, one per offending conversion
  always @(posedge mclk) if (rderr === 1'b1) n_err_pulses++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // offer one word; ready is sampled at the taking edge
  task automatic push(input logic [15:0] w);
    @(posedge mclk);
    valid <= 1'b1;
    result <= w;
    do @(posedge mclk); while (ready !== 1'b1);
    valid <= 1'b0;
  endtask

  task automatic read_word(input int cnt, output logic [31:0] b);
    i_host.open_frame();
    check(oe, 1'b1);
    i_host.shift_bits(cnt, b);
    i_host.close_frame();
    check(oe, 1'b0);
  endtask

  // watchdog sized well above the expected run of about 8100 cycles
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check(setting, 7'h02);
    check({ready, oe, rderr}, 3'h4);
    // configuration rows; dedicated pins all high must be ignored
    foreach (rows[i]) begin
      inv <= rows[i].inv;
      repeat (8) @(posedge mclk);
      i_host.cfg_write(rows[i].cfg);
      check(setting, rows[i].exp);
      push(rows[i].word);
      read_word(16, bits);
      check(bits, rows[i].word ^ {rows[i].exp[0], 15'h0});
    end
    // clocks with the selects high must not move the shifter
    push(16'h9c63);
    i_host.shift_bits(4, bits);
    check(oe, 1'b0);
    read_word(16, bits);
    check(bits, 16'h9c63);
    // unfinished read during conversion, then the word comes back whole
    push(16'h6b2d);
    busy <= 1'b1;
    i_host.open_frame();
    i_host.shift_bits(5, bits);
    n_err_pulses = 0;
    busy <= 1'b0;
    repeat (6) @(posedge mclk);
    check(n_err_pulses, 1);
    i_host.close_frame();
    i_host.open_frame();
    i_host.shift_bits(8, bits);
    busy <= 1'b1;
    i_host.shift_bits(8, b2);
    busy <= 1'b0;
    repeat (6) @(posedge mclk);
    i_host.close_frame();
    check({bits[7:0], b2[7:0]}, 16'h6b2d);
    check(n_err_pulses, 1);
    // dedicated pins rule in hardware and parallel modes; port writes ignored
    hwp <= 6'h2d;
    hwsw <= 1'b1;
    i_host.cfg_write(9'h1c0);
    check(setting, 7'h55);
    ser <= 1'b0;
    hwsw <= 1'b0;
    i_host.cfg_write(9'h1c0);
    check(setting, 7'h55);
    ser <= 1'b1;
    repeat (8) @(posedge mclk);
    check(setting, 7'h02);
    // internal clock choice leaves the slave output off
    ext <= 1'b0;
    i_host.open_frame();
    check(oe, 1'b0);
    i_host.close_frame();
    ext <= 1'b1;
    // fill queue until refused: 32 queued plus one held in the shifter
    @(posedge mclk);
    valid <= 1'b1;
    result <= 16'ha000;
    repeat (40) begin
      @(posedge mclk);
      if (ready === 1'b1) begin
        n++;
        result <= 16'ha000 + 16'(n);
      end
    end
    valid <= 1'b0;
    check(n, 33);
    check(ready, 1'b0);
    // drain oldest first; the 17th bit is the chain input
    for (int i = 0; i < 33; i++) begin
      chain <= i[0];
      read_word(17, bits);
      check(bits, {16'ha000 + 16'(i), i[0]});
    end
    check(ready, 1'b1);
    // reset in mid-run clears the configuration
    i_host.cfg_write(9'h1e4);
    check(setting, 7'h73);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check(setting, 7'h02);
    give_verdict();
  end
endmodule // slave_serial_read_and_config_port_bench
`default_nettype wire
